// file: irq_unit_pkg.sv
`default_nettype none
package irq_unit_pkg;
  // Register map (special function register addresses)
  localparam logic [7:0] ADDR_ENABLE_0 = 8'ha8;
  localparam logic [7:0] ADDR_ENABLE_1 = 8'he8;
  localparam logic [7:0] ADDR_LEVEL_0 = 8'hb8;
  localparam logic [7:0] ADDR_LEVEL_1 = 8'hf8;
  // Request flag register, a block-local choice
  localparam logic [7:0] ADDR_FLAGS_LO = 8'hc0;
  localparam logic [7:0] ADDR_FLAGS_HI = 8'hc1;
  // Controller state readback, a block-local choice
  localparam logic [7:0] ADDR_STATUS = 8'hc2;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam int GATE_BIT = 7;
  localparam int NUM_SRC = 15;
  // Machine cycle of 12 clocks; sample phase index within it
  localparam int PHASES = 12;
  localparam logic [3:0] SAMPLE_PHASE = 4'h9;
  localparam logic [3:0] LAST_PHASE = 4'hb;
  // Source indices in polling order, index 0 polled first
  localparam int SRC_EXT0 = 0;
  localparam int SRC_I2C = 1;
  localparam int SRC_CONV = 2;
  localparam int SRC_TMR0 = 3;
  localparam int SRC_CAP0 = 4;
  localparam int SRC_CMP0 = 5;
  localparam int SRC_EXT1 = 6;
  localparam int SRC_CAP1 = 7;
  localparam int SRC_CMP1 = 8;
  localparam int SRC_TMR1 = 9;
  localparam int SRC_CAP2 = 10;
  localparam int SRC_CMP2 = 11;
  localparam int SRC_UART = 12;
  localparam int SRC_CAP3 = 13;
  localparam int SRC_TMR2 = 14;
  typedef logic [15:0] vector_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
  typedef struct packed {
    logic valid;
    logic high;
    logic [3:0] src;
    vector_t addr;
  } call_req_t;
endpackage
`default_nettype wire

// file: two_level_vectored_irq_unit.sv
// Overview of operation
// - Sample all flags at the sample phase, poll them next machine cycle
// - Enabled unblocked request makes the core perform a long call
// - No vectoring while a same or higher level routine is active
// - Vector only in the last machine cycle of an instruction
// - After return or enable/level register access, one more instruction first
// - Blocked requests are not remembered; every poll is new
// - Timer 0 and timer 1 overflow flags clear on vectoring
// - External flags clear on vectoring only when edge-triggered
// - Call pushes program counter only and loads the chosen vector
// - Return clears the active-level flip-flop, core pops two bytes
// - Level bit 0 selects low priority, 1 selects high
// - High request preempts low routine; high routine never preempted
// - High-level request beats low-level request in the same poll
// - Fixed polling order decides among same-level requests
// - Classic vectors 0003, 000b, 0013, 001b, 0023, 002b
// - Extended vectors 0033 to 0073; capture1 shares 0033
// - Global gate bit 7 of enable bank 0 blocks everything when low
// - Enable bank 0 bits select converter, i2c, uart, timers, externals
// - Enable bank 1 bits select timer2 wrap, matches, captures
// - Software flag writes act like hardware, converter flag cannot be set
//
// Local design decision: the strobed register port.
`default_nettype none
module two_level_vectored_irq_unit #(
  parameter int NUM_SRC = irq_unit_pkg::NUM_SRC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Request sets from peripherals, one-cycle pulses on this clock
  input wire logic [NUM_SRC-1:0] flag_set_i,
  // External pins, active low, asynchronous; tick_set_i is an active-high pulse on this clock
  input wire logic ext_zero_source_n_i,
  input wire logic ext_one_tick_source_n_i,
  input wire logic tick_set_i,
  // Edge mode per external input, 1 = edge-triggered
  input wire logic ext_zero_edge_i,
  input wire logic ext_one_edge_i,
  // Core sequencer
  input wire logic last_cycle_i,
  input wire logic instr_done_i,
  input wire logic return_from_irq_i,
  output logic sample_phase_o,
  output logic cycle_end_o,
  output logic long_call_o,
  output logic [15:0] call_vector_o,
  output logic [NUM_SRC-1:0] flags_o,
  output logic [1:0] level_active_o
);

  logic [3:0] phase;
  logic [7:0] enable_0;
  logic [7:0] enable_1;
  logic [7:0] level_0;
  logic [7:0] level_1;
  logic [NUM_SRC-1:0] flags;
  logic [NUM_SRC-1:0] sampled;
  logic [NUM_SRC-1:0] polled;
  logic [1:0] active;
  logic hold_off;
  logic [1:0] x0_sync;
  logic [1:0] x1_sync;
  logic x0_prev;
  logic x1_prev;
  logic [NUM_SRC-1:0] enables;
  logic [NUM_SRC-1:0] levels;
  logic [NUM_SRC-1:0] hi_req;
  logic [NUM_SRC-1:0] lo_req;
  logic cycle_end;
  logic ctl_access;
  irq_unit_pkg::call_req_t pick;
  irq_unit_pkg::reg_req_t req;
  logic [NUM_SRC-1:0] hw_clear;
  logic [NUM_SRC-1:0] sw_wmask;
  logic [NUM_SRC-1:0] sw_wval;
  logic [NUM_SRC-1:0] next_flags;

  assign req = '{addr: reg_addr_i, wdata: reg_wdata_i, wr: reg_wr_i, rd: reg_rd_i};

  // Lowest set index wins: index 0 is polled first
  function automatic logic [3:0] first_set(input logic [NUM_SRC-1:0] v);
    logic [3:0] r;
    r = 4'h0;
    for (int i = NUM_SRC - 1; i >= 0; i--)
    begin
      if (v[i])
        r = i[3:0];
    end
    return r;
  endfunction

  function automatic irq_unit_pkg::vector_t vector_of(input logic [3:0] s);
    irq_unit_pkg::vector_t v;
    // Vector table
    // vector table
    unique case (s)
      4'h0: v = 16'h0003;
      4'h1: v = 16'h002b;
      4'h2: v = 16'h0053;
      4'h3: v = 16'h000b;
      4'h4: v = 16'h0033;
      4'h5: v = 16'h005b;
      4'h6: v = 16'h0013;
      // Capture 1 shares the capture 0 entry; unconfirmed, kept on purpose
      4'h7: v = 16'h0033;
      4'h8: v = 16'h0063;
      4'h9: v = 16'h001b;
      4'ha: v = 16'h0043;
      4'hb: v = 16'h006b;
      4'hc: v = 16'h0023;
      4'hd: v = 16'h004b;
      4'he: v = 16'h0073;
      default: v = 16'h0000;
    endcase
    return v;
  endfunction

  // Maps byte-wide enable/level banks onto polling-order indices
  function automatic logic [NUM_SRC-1:0] to_order(input logic [7:0] b0, input logic [7:0] b1);
    logic [NUM_SRC-1:0] r;
    r = '0;
    r[irq_unit_pkg::SRC_EXT0] = b0[0];
    r[irq_unit_pkg::SRC_TMR0] = b0[1];
    r[irq_unit_pkg::SRC_EXT1] = b0[2];
    r[irq_unit_pkg::SRC_TMR1] = b0[3];
    r[irq_unit_pkg::SRC_UART] = b0[4];
    r[irq_unit_pkg::SRC_I2C] = b0[5];
    r[irq_unit_pkg::SRC_CONV] = b0[6];
    r[irq_unit_pkg::SRC_CAP0] = b1[0];
    r[irq_unit_pkg::SRC_CAP1] = b1[1];
    r[irq_unit_pkg::SRC_CAP2] = b1[2];
    r[irq_unit_pkg::SRC_CAP3] = b1[3];
    r[irq_unit_pkg::SRC_CMP0] = b1[4];
    r[irq_unit_pkg::SRC_CMP1] = b1[5];
    r[irq_unit_pkg::SRC_CMP2] = b1[6];
    r[irq_unit_pkg::SRC_TMR2] = b1[7];
    return r;
  endfunction

  // Machine-cycle phase divider
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      phase <= 4'h0;
    else if (phase == irq_unit_pkg::LAST_PHASE)
      phase <= 4'h0;
    else
      phase <= phase + 4'h1;
  end

  assign cycle_end = (phase == irq_unit_pkg::LAST_PHASE);
  assign sample_phase_o = (phase == irq_unit_pkg::SAMPLE_PHASE);
  assign cycle_end_o = cycle_end;

  // Pin synchronisers; only the second stage is read
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      x0_sync <= 2'b11;
      x1_sync <= 2'b11;
      x0_prev <= 1'b1;
      x1_prev <= 1'b1;
    end
    else
    begin
      x0_sync <= {x0_sync[0], ext_zero_source_n_i};
      x1_sync <= {x1_sync[0], ext_one_tick_source_n_i};
      x0_prev <= x0_sync[1];
      x1_prev <= x1_sync[1];
    end
  end

  assign ctl_access = (req.wr || req.rd) &&
                      (req.addr == irq_unit_pkg::ADDR_ENABLE_0 ||
                       req.addr == irq_unit_pkg::ADDR_ENABLE_1 ||
                       req.addr == irq_unit_pkg::ADDR_LEVEL_0 ||
                       req.addr == irq_unit_pkg::ADDR_LEVEL_1);

  // Enable and level registers
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      enable_0 <= irq_unit_pkg::RESET_BYTE;
      enable_1 <= irq_unit_pkg::RESET_BYTE;
      level_0 <= irq_unit_pkg::RESET_BYTE;
      level_1 <= irq_unit_pkg::RESET_BYTE;
    end
    else if (req.wr)
    begin
      if (req.addr == irq_unit_pkg::ADDR_ENABLE_0)
        enable_0 <= req.wdata;
      if (req.addr == irq_unit_pkg::ADDR_ENABLE_1)
        enable_1 <= req.wdata;
      // Bit 7 of level bank 0 is reserved and reads zero
      if (req.addr == irq_unit_pkg::ADDR_LEVEL_0)
        level_0 <= {1'b0, req.wdata[6:0]};
      if (req.addr == irq_unit_pkg::ADDR_LEVEL_1)
        level_1 <= req.wdata;
    end
  end

  assign enables = to_order(enable_0, enable_1);
  assign levels = to_order(level_0, level_1);

  // Software flag writes
  always_comb
  begin
    sw_wmask = '0;
    sw_wval = '0;
    if (req.wr && req.addr == irq_unit_pkg::ADDR_FLAGS_LO)
    begin
      sw_wmask[7:0] = 8'hff;
      sw_wval[7:0] = req.wdata;
    end
    if (req.wr && req.addr == irq_unit_pkg::ADDR_FLAGS_HI)
    begin
      sw_wmask[NUM_SRC-1:8] = '1;
      sw_wval[NUM_SRC-1:8] = req.wdata[NUM_SRC-9:0];
    end
  end

  // Flag update: hardware sets win over any clear in the same cycle, except that level-mode external flags follow the pin
  always_comb
  begin
    next_flags = flags;
    for (int i = 0; i < NUM_SRC; i++)
    begin
      if (sw_wmask[i])
        next_flags[i] = sw_wval[i];
    end
    if (sw_wmask[irq_unit_pkg::SRC_CONV] && !flags[irq_unit_pkg::SRC_CONV])
      next_flags[irq_unit_pkg::SRC_CONV] = 1'b0;
    next_flags = next_flags & ~hw_clear;
    next_flags = next_flags | flag_set_i;
    // Edge mode: falling edge sets; level mode: flag follows pin
    if (ext_zero_edge_i)
    begin
      if (x0_prev && !x0_sync[1])
        next_flags[irq_unit_pkg::SRC_EXT0] = 1'b1;
    end
    else
      next_flags[irq_unit_pkg::SRC_EXT0] = !x0_sync[1];
    if (ext_one_edge_i)
    begin
      if (x1_prev && !x1_sync[1])
        next_flags[irq_unit_pkg::SRC_EXT1] = 1'b1;
    end
    else
      next_flags[irq_unit_pkg::SRC_EXT1] = !x1_sync[1];
    // Seconds tick is ORed onto the external 1 request
    if (tick_set_i)
      next_flags[irq_unit_pkg::SRC_EXT1] = 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      flags <= '0;
    else
      flags <= next_flags;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      sampled <= '0;
    else if (sample_phase_o)
      sampled <= flags;
  end

  // poll next cycle
  // The poll at a cycle end sees the samples of the machine cycle before;
  // a stale poll of a source just served is held off by the level flip-flops
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      polled <= '0;
    else if (cycle_end)
      polled <= sampled;
  end

  assign hi_req = (enable_0[irq_unit_pkg::GATE_BIT] ? polled & enables : '0) & levels;
  assign lo_req = (enable_0[irq_unit_pkg::GATE_BIT] ? polled & enables : '0) & ~levels;

  always_comb
  begin
    pick = '0;
    if (!active[1] && |hi_req)
    begin
      pick.valid = 1'b1;
      pick.high = 1'b1;
      pick.src = first_set(hi_req);
    end
    else if (!active[1] && !active[0] && |lo_req)
    begin
      pick.valid = 1'b1;
      pick.src = first_set(lo_req);
    end
    pick.addr = vector_of(pick.src);
  end

  // one instruction after return or access
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      hold_off <= 1'b0;
    else if (return_from_irq_i || ctl_access)
      hold_off <= 1'b1;
    else if (instr_done_i)
      hold_off <= 1'b0;
  end

  assign long_call_o = pick.valid && cycle_end && last_cycle_i && !hold_off &&
                       !return_from_irq_i && !ctl_access;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      call_vector_o <= 16'h0000;
    else if (long_call_o)
      call_vector_o <= pick.addr;
  end

  always_comb
  begin
    hw_clear = '0;
    if (long_call_o)
    begin
      if (pick.src == irq_unit_pkg::SRC_TMR0[3:0] || pick.src == irq_unit_pkg::SRC_TMR1[3:0])
        hw_clear[pick.src] = 1'b1;
      if (pick.src == irq_unit_pkg::SRC_EXT0[3:0] && ext_zero_edge_i)
        hw_clear[pick.src] = 1'b1;
      if (pick.src == irq_unit_pkg::SRC_EXT1[3:0] && ext_one_edge_i)
        hw_clear[pick.src] = 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      active <= 2'b00;
    else if (long_call_o)
      active[pick.high] <= 1'b1;
    else if (return_from_irq_i)
    begin
      if (active[1])
        active[1] <= 1'b0;
      else
        active[0] <= 1'b0;
    end
  end

  assign flags_o = flags;
  assign level_active_o = active;

  // Read data one cycle after the strobe; unmapped reads return zero
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      reg_rdata_o <= 8'h00;
    else if (req.rd)
    begin
      unique case (req.addr)
        irq_unit_pkg::ADDR_ENABLE_0: reg_rdata_o <= enable_0;
        irq_unit_pkg::ADDR_ENABLE_1: reg_rdata_o <= enable_1;
        irq_unit_pkg::ADDR_LEVEL_0: reg_rdata_o <= level_0;
        irq_unit_pkg::ADDR_LEVEL_1: reg_rdata_o <= level_1;
        irq_unit_pkg::ADDR_FLAGS_LO: reg_rdata_o <= flags[7:0];
        irq_unit_pkg::ADDR_FLAGS_HI: reg_rdata_o <= {1'b0, flags[NUM_SRC-1:8]};
        irq_unit_pkg::ADDR_STATUS: reg_rdata_o <= {5'h00, hold_off, active};
        default: reg_rdata_o <= 8'h00;
      endcase
    end
    else
      reg_rdata_o <= 8'h00;
  end

  property p_gate_blocks;
    @(posedge clk_i) disable iff (!rst_n_i)
      !enable_0[irq_unit_pkg::GATE_BIT] |-> !long_call_o;
  endproperty
  a_gate_blocks: assert property (p_gate_blocks) else $error("call with gate low");

  property p_last_cycle;
    @(posedge clk_i) disable iff (!rst_n_i)
      long_call_o |-> last_cycle_i && cycle_end;
  endproperty
  a_last_cycle: assert property (p_last_cycle) else $error("call outside last cycle");

  property p_high_no_preempt;
    @(posedge clk_i) disable iff (!rst_n_i)
      active[1] |-> !long_call_o;
  endproperty
  a_high_no_preempt: assert property (p_high_no_preempt) else $error("high preempted");

  property p_low_block;
    @(posedge clk_i) disable iff (!rst_n_i)
      (active[0] && long_call_o) |-> pick.high;
  endproperty
  a_low_block: assert property (p_low_block) else $error("low preempted low");

  property p_holdoff;
    @(posedge clk_i) disable iff (!rst_n_i)
      (return_from_irq_i || ctl_access) |=> hold_off && !long_call_o;
  endproperty
  a_holdoff: assert property (p_holdoff) else $error("call right after return");

  property p_vector_loaded;
    @(posedge clk_i) disable iff (!rst_n_i)
      long_call_o |=> call_vector_o == vector_of($past(pick.src));
  endproperty
  a_vector_loaded: assert property (p_vector_loaded) else $error("wrong vector");

  property p_active_set;
    @(posedge clk_i) disable iff (!rst_n_i)
      long_call_o && pick.high |=> active[1];
  endproperty
  a_active_set: assert property (p_active_set) else $error("level not marked");

  property p_timer_clear;
    @(posedge clk_i) disable iff (!rst_n_i)
      long_call_o && pick.src == irq_unit_pkg::SRC_TMR0[3:0] &&
      !flag_set_i[irq_unit_pkg::SRC_TMR0] |=> !flags[irq_unit_pkg::SRC_TMR0];
  endproperty
  a_timer_clear: assert property (p_timer_clear) else $error("timer 0 flag kept");

  property p_uart_kept;
    @(posedge clk_i) disable iff (!rst_n_i)
      long_call_o && pick.src == irq_unit_pkg::SRC_UART[3:0] && !req.wr
      |=> flags[irq_unit_pkg::SRC_UART];
  endproperty
  a_uart_kept: assert property (p_uart_kept) else $error("uart flag cleared");

  property p_high_first;
    @(posedge clk_i) disable iff (!rst_n_i)
      long_call_o && |hi_req |-> pick.high;
  endproperty
  a_high_first: assert property (p_high_first) else $error("low chosen over high");

endmodule // two_level_vectored_irq_unit
`default_nettype wire

// file: core_seq_model.sv
`default_nettype none
module core_seq_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Controller side
  input wire logic cycle_end_i,
  input wire logic long_call_i,
  output logic last_cycle_o,
  output logic instr_done_o,
  output logic return_from_irq_o,
  // Bench control
  input wire logic two_cycle_i,
  input wire logic ret_req_i,
  output logic [7:0] depth_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic second;
  logic ret_pend;
  assign last_cycle_o = !two_cycle_i || second;
  assign instr_done_o = cycle_end_i && last_cycle_o;
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      second <= 1'b0;
    else if (cycle_end_i && two_cycle_i)
      second <= !second;
  end
  // return runs as its own instruction, starting a fresh machine cycle
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      ret_pend <= 1'b0;
      return_from_irq_o <= 1'b0;
    end
    else
    begin
      return_from_irq_o <= ret_pend && instr_done_o;
      ret_pend <= ret_req_i || (ret_pend && !instr_done_o);
    end
  end
  // call pushes two bytes of program counter, return pops them
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      depth_o <= 8'h00;
    else if (long_call_i)
      depth_o <= depth_o + 8'h02;
    else if (return_from_irq_o)
      depth_o <= depth_o - 8'h02;
  end
endmodule // core_seq_model
`default_nettype wire

// file: two_level_vectored_irq_unit_bench.sv
`default_nettype none
module two_level_vectored_irq_unit_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [15:0] vec;
    logic [14:0] flags;
    logic [1:0] lvl;
  } call_note_t;
  logic clk_i, rst_n_i, reg_wr_i, reg_rd_i, tick_set_i, last_cycle_i, instr_done_i;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, depth;
  logic [14:0] flag_set_i, flags_o, fl;
  logic ext_zero_source_n_i, ext_one_tick_source_n_i, ext_zero_edge_i, ext_one_edge_i;
  logic return_from_irq_i, sample_phase_o, cycle_end_o, long_call_o, two_cycle, ret_req;
  logic [15:0] call_vector_o;
  logic [1:0] level_active_o;
  logic rd_d, call_d;
  int since_end = 0;
  logic [31:0] seed;
  int errors, total_checks;
  int calls = 0;
  logic [7:0] rd_q[$];
  call_note_t call_q[$];
  call_note_t note;
  logic [15:0] vtab [15] = '{16'h0003, 16'h002b, 16'h0053, 16'h000b, 16'h0033,
    16'h005b, 16'h0013, 16'h0033, 16'h0063, 16'h001b, 16'h0043, 16'h006b,
    16'h0023, 16'h004b, 16'h0073};

  two_level_vectored_irq_unit #(.NUM_SRC(irq_unit_pkg::NUM_SRC)) dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .flag_set_i(flag_set_i), .ext_zero_source_n_i(ext_zero_source_n_i),
    .ext_one_tick_source_n_i(ext_one_tick_source_n_i), .tick_set_i(tick_set_i),
    .ext_zero_edge_i(ext_zero_edge_i), .ext_one_edge_i(ext_one_edge_i),
    .last_cycle_i(last_cycle_i), .instr_done_i(instr_done_i),
    .return_from_irq_i(return_from_irq_i), .sample_phase_o(sample_phase_o),
    .cycle_end_o(cycle_end_o), .long_call_o(long_call_o), .call_vector_o(call_vector_o),
    .flags_o(flags_o), .level_active_o(level_active_o));

  core_seq_model core (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .cycle_end_i(cycle_end_o), .long_call_i(long_call_o),
    .last_cycle_o(last_cycle_i), .instr_done_o(instr_done_i),
    .return_from_irq_o(return_from_irq_i), .two_cycle_i(two_cycle), .ret_req_i(ret_req),
    .depth_o(depth));

  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    total_checks++;
    if (seen !== want)
    begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Every call is matched against the oldest note; a call with no note is a fault
  always @(posedge clk_i)
  begin
    if (rd_d)
      check(16'(reg_rdata_o), 16'(rd_q.pop_front()));
    if (call_d)
    begin
      calls++;
      if (call_q.size() == 0)
        check(16'h0001, 16'h0000);
      else
      begin
        note = call_q.pop_front();
        check(call_vector_o, note.vec);
        check(16'(flags_o), 16'(note.flags));
        check(16'(level_active_o), 16'(note.lvl));
      end
    end
    if (long_call_o)
      check({14'h0000, cycle_end_o, last_cycle_i}, 16'h0003);
    if (sample_phase_o)
      check(16'(since_end), 16'(irq_unit_pkg::SAMPLE_PHASE));
    since_end <= (!rst_n_i || cycle_end_o) ? 0 : since_end + 1;
    rd_d <= reg_rd_i;
    call_d <= long_call_o;
  end

  // Tasks start just after a rising edge and leave an idle edge behind them
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_wr_i <= 1'b1;
    @(posedge clk_i);
    reg_wr_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    rd_q.push_back(exp);
    reg_addr_i <= a;
    reg_rd_i <= 1'b1;
    @(posedge clk_i);
    reg_rd_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic pulse(input logic [14:0] m, input logic t);
    flag_set_i <= m;
    tick_set_i <= t;
    @(posedge clk_i);
    flag_set_i <= '0;
    tick_set_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wait_mc(input int n);
    repeat (n * irq_unit_pkg::PHASES) @(posedge clk_i);
  endtask

  task automatic expect_call(input logic [15:0] v, input logic [14:0] f, input logic [1:0] l);
    call_q.push_back('{vec: v, flags: f, lvl: l});
  endtask

  task automatic wait_call();
    int c0;
    int k;
    c0 = calls;
    k = 0;
    while (calls == c0 && k < 2000)
    begin
      @(posedge clk_i);
      k++;
    end
    if (calls == c0)
    begin
      errors++;
      test_done();
    end
  endtask

  task automatic ret();
    ret_req <= 1'b1;
    @(posedge clk_i);
    ret_req <= 1'b0;
    wait_mc(2);
  endtask

  initial
  begin
    rst_n_i = 1'b0;
    {reg_wr_i, reg_rd_i, tick_set_i, two_cycle, ret_req} = '0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    flag_set_i = '0;
    {ext_zero_source_n_i, ext_one_tick_source_n_i, ext_zero_edge_i, ext_one_edge_i} = 4'hf;
    seed = 32'd27;
    errors = 0;
    total_checks = 0;
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    rd(irq_unit_pkg::ADDR_ENABLE_0, irq_unit_pkg::RESET_BYTE);
    rd(irq_unit_pkg::ADDR_ENABLE_1, irq_unit_pkg::RESET_BYTE);
    rd(irq_unit_pkg::ADDR_LEVEL_1, irq_unit_pkg::RESET_BYTE);
    rd(8'h10, 8'h00);
    seed = xs(seed);
    wr(irq_unit_pkg::ADDR_ENABLE_1, seed[7:0]);
    rd(irq_unit_pkg::ADDR_ENABLE_1, seed[7:0]);
    seed = xs(seed);
    wr(irq_unit_pkg::ADDR_LEVEL_0, seed[7:0]);
    rd(irq_unit_pkg::ADDR_LEVEL_0, {1'b0, seed[6:0]});
    seed = xs(seed);
    wr(irq_unit_pkg::ADDR_LEVEL_1, seed[7:0]);
    rd(irq_unit_pkg::ADDR_LEVEL_1, seed[7:0]);
    wr(irq_unit_pkg::ADDR_LEVEL_1, 8'h00);
    wr(irq_unit_pkg::ADDR_LEVEL_0, 8'h00);
    wr(irq_unit_pkg::ADDR_ENABLE_1, 8'h00);
    // Converter flag refuses a software set, the i2c flag accepts it
    wr(irq_unit_pkg::ADDR_FLAGS_LO, 8'h06);
    rd(irq_unit_pkg::ADDR_FLAGS_LO, 8'h02);
    wr(irq_unit_pkg::ADDR_FLAGS_LO, 8'h00);
    // Gate low: request ignored, then cancelled before the gate opens
    wr(irq_unit_pkg::ADDR_ENABLE_0, 8'h01);
    pulse(15'h0001, 1'b0);
    wait_mc(4);
    rd(irq_unit_pkg::ADDR_FLAGS_LO, 8'h01);
    wr(irq_unit_pkg::ADDR_FLAGS_LO, 8'h00);
    wr(irq_unit_pkg::ADDR_ENABLE_0, 8'h81);
    wait_mc(4);
    // All sources pending at once, all low level: served in polling order
    wr(irq_unit_pkg::ADDR_ENABLE_0, 8'hff);
    wr(irq_unit_pkg::ADDR_ENABLE_1, 8'hff);
    fl = 15'h7fff;
    for (int i = 0; i < 15; i++)
    begin
      if (i == 0 || i == 3 || i == 6 || i == 9)
        fl[i] = 1'b0;
      expect_call(vtab[i], fl, 2'b01);
      if (i == 0)
        pulse(15'h7fff, 1'b1);
      wait_call();
      fl[i] = 1'b0;
      if (i < 8)
        wr(irq_unit_pkg::ADDR_FLAGS_LO, fl[7:0]);
      else
        wr(irq_unit_pkg::ADDR_FLAGS_HI, {1'b0, fl[14:8]});
      ret();
    end
    rd(irq_unit_pkg::ADDR_FLAGS_HI, 8'h00);
    // Two-cycle instructions: call only in the final machine cycle
    two_cycle <= 1'b1;
    expect_call(16'h001b, 15'h0000, 2'b01);
    pulse(15'h0200, 1'b0);
    wait_call();
    ret();
    two_cycle <= 1'b0;
    // Uart at high level beats ext0, blocks it, then preempts it
    wr(irq_unit_pkg::ADDR_LEVEL_0, 8'h10);
    wr(irq_unit_pkg::ADDR_ENABLE_1, 8'h00);
    wr(irq_unit_pkg::ADDR_ENABLE_0, 8'h91);
    expect_call(16'h0023, 15'h1001, 2'b10);
    pulse(15'h1001, 1'b0);
    wait_call();
    wait_mc(4);
    expect_call(16'h0003, 15'h0000, 2'b01);
    wr(irq_unit_pkg::ADDR_FLAGS_HI, 8'h00);
    ret();
    wait_call();
    expect_call(16'h0023, 15'h1000, 2'b11);
    pulse(15'h1000, 1'b0);
    wait_call();
    wr(irq_unit_pkg::ADDR_FLAGS_HI, 8'h00);
    ret();
    ret();
    rd(irq_unit_pkg::ADDR_STATUS, 8'h00);
    // Level-mode pin: flag kept on vectoring, follows the pin afterwards
    wr(irq_unit_pkg::ADDR_LEVEL_0, 8'h00);
    ext_zero_edge_i <= 1'b0;
    wr(irq_unit_pkg::ADDR_ENABLE_0, 8'h81);
    expect_call(16'h0003, 15'h0001, 2'b01);
    ext_zero_source_n_i <= 1'b0;
    wait_call();
    ext_zero_source_n_i <= 1'b1;
    wait_mc(1);
    rd(irq_unit_pkg::ADDR_FLAGS_LO, 8'h00);
    ret();
    wr(irq_unit_pkg::ADDR_ENABLE_0, 8'h00);
    check(16'(depth), 16'h0000);
    check(16'(call_q.size()), 16'h0000);
    test_done();
  end
endmodule // two_level_vectored_irq_unit_bench
`default_nettype wire
